// ===== dtio_defs.vh
`ifndef DTIO_DEFS_VH
`define DTIO_DEFS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define DTIO_CLK_MHZ 250
`define DTIO_TICK_MS 100
`define DTIO_PULSE_MAX_KHZ 100
`define DTIO_PULSE_MIN_HALF (`DTIO_CLK_MHZ * 1000 / (2 * `DTIO_PULSE_MAX_KHZ))
`define DTIO_DELAY_MAX 16'h8ca0

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DTIO_OFF_CURVE 8'h00
`define DTIO_OFF_BELOW 8'h04
`define DTIO_OFF_DLY1 8'h08
`define DTIO_OFF_DLY2 8'h0c
`define DTIO_OFF_DLY3 8'h10
`define DTIO_OFF_POL 8'h14
`define DTIO_OFF_MODE 8'h18
`define DTIO_OFF_SWFN 8'h1c
`define DTIO_OFF_RLFN 8'h20
`define DTIO_OFF_HALF 8'h24
`define DTIO_OFF_STAT 8'h28

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define DTIO_RST_CURVE 12'h321
`define DTIO_RST_BELOW 3'h0
`define DTIO_RST_DLY 16'h0000
`define DTIO_RST_POL 5'h00
`define DTIO_RST_MODE 1'h0
`define DTIO_RST_SWFN 5'h00
`define DTIO_RST_RLFN 5'h02
`define DTIO_RST_HALF 16'h04e2
`define DTIO_FUNC_NONE 5'h00
`define DTIO_FUNC_RUN 5'h01
`define DTIO_FUNC_FAULT 5'h02
`define DTIO_CURVE_MAX 4'h5
`define DTIO_CURVE_4PT 3'h4
`define DTIO_RESP_OKAY 2'h0
`define DTIO_RESP_SLVERR 2'h2

`endif

// ===== dtio_delay_timer.v
`timescale 1ns/1ps
`include "dtio_defs.vh"

module dtio_delay_timer (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, active low
	input wire tick, // 0.1 s enable pulse
	input wire level, // polarity-corrected terminal level
	input wire [15:0] delay, // hold-off in 0.1 s steps
	output reg state // accepted terminal state
);

	reg prev;
	reg [15:0] count;

	// ----------------------------------------
	// hold-off counter
	// ----------------------------------------
	// a new change restarts the count; state follows once count reaches delay
	always @(posedge aclk) begin
		if (!aresetn) begin
			prev <= 1'b0;
			state <= 1'b0;
			count <= 16'h0000;
		end else begin
			prev <= level;
			if (level != prev) begin
				count <= 16'h0000;
			end else if (state == level) begin
				count <= 16'h0000;
			end else if (count >= delay) begin
				state <= level;
				count <= 16'h0000;
			end else if (tick) begin
				count <= count + 16'h0001;
			end
		end
	end

endmodule

// ===== dtio_top.v
`timescale 1ns/1ps
`include "dtio_defs.vh"

module dtio_top #(
	parameter TICK_CYCLES = `DTIO_TICK_MS * 1000 * `DTIO_CLK_MHZ // cycles per 0.1 s
) (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, active low
	input wire [7:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output wire s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write byte strobes
	input wire s_axi_wvalid, // write data valid
	output wire s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [7:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output wire s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire [47:0] analog_scaled, // curve result per input, 16 bits each
	input wire [47:0] analog_min_setting, // curve value at minimum input, per input
	input wire [2:0] analog_below_min, // reading below curve minimum, per input
	output reg [47:0] analog_result, // conditioned result per input
	output reg [8:0] analog_curve_code, // selected curve 1..5, 3 bits per input
	output reg [2:0] analog_four_point, // selected curve is four-point
	input wire digital_in_one, // terminal one, low when grounded
	input wire digital_in_two, // terminal two, low when grounded
	input wire digital_in_three, // terminal three, low when grounded
	input wire digital_in_four, // terminal four, low when grounded
	input wire digital_in_five, // terminal five, low when grounded
	output wire [4:0] digital_active, // accepted asserted state per terminal
	input wire drive_running, // drive running and producing output
	input wire drive_faulted, // drive stopped on a fault
	output reg fast_multiplexed_output, // fast output terminal level
	output wire fast_pulse_output_mode, // fast terminal in pulse mode
	output reg open_collector_switch_output, // switch function level
	output reg first_relay_contact // relay one coil drive
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [11:0] curve_select_param;
	reg [2:0] below_minimum_select_param;
	reg [15:0] input_one_delay_param;
	reg [15:0] input_two_delay_param;
	reg [15:0] input_three_delay_param;
	reg [4:0] input_polarity_param;
	reg fast_output_mode_param;
	reg [4:0] switch_output_function_param;
	reg [4:0] relay_one_function_param;
	reg [15:0] pulse_half_period;

	reg aw_hold;
	reg w_hold;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire aw_take;
	wire w_take;
	wire have_aw;
	wire have_w;
	wire do_write;
	wire [7:0] wa;
	wire [31:0] wd;
	wire [3:0] ws;
	wire [31:0] mask;
	wire [31:0] status_word;

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	// address and data are taken in either order; the write acts once both are in
	assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
	assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign have_aw = aw_hold | aw_take;
	assign have_w = w_hold | w_take;
	assign do_write = have_aw & have_w;
	assign wa = aw_hold ? aw_addr : s_axi_awaddr;
	assign wd = w_hold ? w_data : s_axi_wdata;
	assign ws = w_hold ? w_strb : s_axi_wstrb;
	assign mask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

	// merge strobed bytes of the new data into the old word
	function [31:0] dtio_merge;
		input [31:0] old;
		input [31:0] new_word;
		input [31:0] m;
		begin
			dtio_merge = (old & ~m) | (new_word & m);
		end
	endfunction

	// clamp a delay setting to the longest hold-off
	function [15:0] dtio_clamp_dly;
		input [15:0] v;
		begin
			dtio_clamp_dly = (v > `DTIO_DELAY_MAX) ? `DTIO_DELAY_MAX : v;
		end
	endfunction

	// shortest half period, cut to the register width on purpose
	localparam integer MIN_HALF_FULL = `DTIO_PULSE_MIN_HALF;
	localparam [15:0] MIN_HALF = MIN_HALF_FULL[15:0];

	// raise a pulse half period to the shortest allowed
	function [15:0] dtio_clamp_half;
		input [15:0] v;
		begin
			dtio_clamp_half = (v < MIN_HALF) ? MIN_HALF : v;
		end
	endfunction

	wire [31:0] m_curve = dtio_merge({20'h00000, curve_select_param}, wd, mask);
	wire [31:0] m_below = dtio_merge({23'h000000, below_minimum_select_param[2], 3'h0,
		below_minimum_select_param[1], 3'h0, below_minimum_select_param[0]}, wd, mask);
	wire [31:0] m_dly1 = dtio_merge({16'h0000, input_one_delay_param}, wd, mask);
	wire [31:0] m_dly2 = dtio_merge({16'h0000, input_two_delay_param}, wd, mask);
	wire [31:0] m_dly3 = dtio_merge({16'h0000, input_three_delay_param}, wd, mask);
	wire [31:0] m_pol = dtio_merge({15'h0000, input_polarity_param[4], 3'h0,
		input_polarity_param[3], 3'h0, input_polarity_param[2], 3'h0,
		input_polarity_param[1], 3'h0, input_polarity_param[0]}, wd, mask);
	wire [31:0] m_mode = dtio_merge({31'h00000000, fast_output_mode_param}, wd, mask);
	wire [31:0] m_swfn = dtio_merge({27'h0000000, switch_output_function_param}, wd, mask);
	wire [31:0] m_rlfn = dtio_merge({27'h0000000, relay_one_function_param}, wd, mask);
	wire [31:0] m_half = dtio_merge({16'h0000, pulse_half_period}, wd, mask);

	// holding registers, register writes and the write response
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DTIO_RESP_OKAY;
			curve_select_param <= `DTIO_RST_CURVE;
			below_minimum_select_param <= `DTIO_RST_BELOW;
			input_one_delay_param <= `DTIO_RST_DLY;
			input_two_delay_param <= `DTIO_RST_DLY;
			input_three_delay_param <= `DTIO_RST_DLY;
			input_polarity_param <= `DTIO_RST_POL;
			fast_output_mode_param <= `DTIO_RST_MODE;
			switch_output_function_param <= `DTIO_RST_SWFN;
			relay_one_function_param <= `DTIO_RST_RLFN;
			pulse_half_period <= `DTIO_RST_HALF;
		end else begin
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `DTIO_RESP_OKAY;
				if (wa[7:2] == `DTIO_OFF_CURVE >> 2) begin
					curve_select_param <= m_curve[11:0];
				end else if (wa[7:2] == `DTIO_OFF_BELOW >> 2) begin
					below_minimum_select_param <= {m_below[8], m_below[4], m_below[0]};
				end else if (wa[7:2] == `DTIO_OFF_DLY1 >> 2) begin
					input_one_delay_param <= dtio_clamp_dly(m_dly1[15:0]);
				end else if (wa[7:2] == `DTIO_OFF_DLY2 >> 2) begin
					input_two_delay_param <= dtio_clamp_dly(m_dly2[15:0]);
				end else if (wa[7:2] == `DTIO_OFF_DLY3 >> 2) begin
					input_three_delay_param <= dtio_clamp_dly(m_dly3[15:0]);
				end else if (wa[7:2] == `DTIO_OFF_POL >> 2) begin
					input_polarity_param <= {m_pol[16], m_pol[12], m_pol[8], m_pol[4],
						m_pol[0]};
				end else if (wa[7:2] == `DTIO_OFF_MODE >> 2) begin
					fast_output_mode_param <= m_mode[0];
				end else if (wa[7:2] == `DTIO_OFF_SWFN >> 2) begin
					switch_output_function_param <= m_swfn[4:0];
				end else if (wa[7:2] == `DTIO_OFF_RLFN >> 2) begin
					relay_one_function_param <= m_rlfn[4:0];
				end else if (wa[7:2] == `DTIO_OFF_HALF >> 2) begin
					pulse_half_period <= dtio_clamp_half(m_half[15:0]);
				end else begin
					s_axi_bresp <= `DTIO_RESP_SLVERR;
				end
			end else begin
				if (aw_take) begin
					aw_hold <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (w_take) begin
					w_hold <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
			end
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;

	// decode the read address and answer one cycle after it is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `DTIO_RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `DTIO_RESP_OKAY;
			if (s_axi_araddr[7:2] == `DTIO_OFF_CURVE >> 2) begin
				s_axi_rdata <= {20'h00000, curve_select_param};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_BELOW >> 2) begin
				s_axi_rdata <= {23'h000000, below_minimum_select_param[2], 3'h0,
					below_minimum_select_param[1], 3'h0, below_minimum_select_param[0]};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_DLY1 >> 2) begin
				s_axi_rdata <= {16'h0000, input_one_delay_param};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_DLY2 >> 2) begin
				s_axi_rdata <= {16'h0000, input_two_delay_param};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_DLY3 >> 2) begin
				s_axi_rdata <= {16'h0000, input_three_delay_param};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_POL >> 2) begin
				s_axi_rdata <= m_pol_read(input_polarity_param);
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_MODE >> 2) begin
				s_axi_rdata <= {31'h00000000, fast_output_mode_param};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_SWFN >> 2) begin
				s_axi_rdata <= {27'h0000000, switch_output_function_param};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_RLFN >> 2) begin
				s_axi_rdata <= {27'h0000000, relay_one_function_param};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_HALF >> 2) begin
				s_axi_rdata <= {16'h0000, pulse_half_period};
			end else if (s_axi_araddr[7:2] == `DTIO_OFF_STAT >> 2) begin
				s_axi_rdata <= status_word;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `DTIO_RESP_SLVERR;
			end
		end
	end

	// spread the polarity bits one per decimal digit nibble
	function [31:0] m_pol_read;
		input [4:0] p;
		begin
			m_pol_read = {15'h0000, p[4], 3'h0, p[3], 3'h0, p[2], 3'h0, p[1], 3'h0, p[0]};
		end
	endfunction

	// ----------------------------------------
	// analog inputs
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_analog
			wire [3:0] digit = curve_select_param[4 * gi + 3:4 * gi];
			wire digit_ok = (digit != 4'h0) && (digit <= `DTIO_CURVE_MAX);
			wire [2:0] code = digit_ok ? digit[2:0] : 3'h1;

			// curve choice and below-minimum substitution per input
			always @(posedge aclk) begin
				if (!aresetn) begin
					analog_curve_code[3 * gi + 2:3 * gi] <= 3'h1;
					analog_four_point[gi] <= 1'b0;
					analog_result[16 * gi + 15:16 * gi] <= 16'h0000;
				end else begin
					analog_curve_code[3 * gi + 2:3 * gi] <= code;
					analog_four_point[gi] <= (code >= `DTIO_CURVE_4PT);
					if (!analog_below_min[gi]) begin
						analog_result[16 * gi + 15:16 * gi] <= analog_scaled[16 * gi + 15:16 * gi];
					end else if (below_minimum_select_param[gi]) begin
						analog_result[16 * gi + 15:16 * gi] <= 16'h0000;
					end else begin
						analog_result[16 * gi + 15:16 * gi] <=
							analog_min_setting[16 * gi + 15:16 * gi];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// digital inputs
	// ----------------------------------------
	reg [24:0] tick_count;
	reg tick;
	reg [4:0] pin_sync;
	wire [4:0] pin_level = {digital_in_five, digital_in_four, digital_in_three,
		digital_in_two, digital_in_one};
	wire [4:0] asserted_level = ~pin_sync ^ input_polarity_param;
	wire [47:0] delay_set = {input_three_delay_param, input_two_delay_param,
		input_one_delay_param};

	// 0.1 s prescaler and terminal sampling
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_count <= 25'h0000000;
			tick <= 1'b0;
			pin_sync <= 5'h1f;
		end else begin
			pin_sync <= pin_level;
			if (tick_count == TICK_CYCLES - 1) begin
				tick_count <= 25'h0000000;
				tick <= 1'b1;
			end else begin
				tick_count <= tick_count + 25'h0000001;
				tick <= 1'b0;
			end
		end
	end

	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_digital
			if (gi < 3) begin : g_timed
				dtio_delay_timer u_timer (
					.aclk(aclk),
					.aresetn(aresetn),
					.tick(tick),
					.level(asserted_level[gi]),
					.delay(delay_set[16 * gi + 15:16 * gi]),
					.state(digital_active[gi])
				);
			end else begin : g_direct
				reg state;
				// terminals four and five follow without hold-off
				always @(posedge aclk) begin
					if (!aresetn) begin
						state <= 1'b0;
					end else begin
						state <= asserted_level[gi];
					end
				end
				assign digital_active[gi] = state;
			end
		end
	endgenerate

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// map a function selection to its drive state
	function dtio_func;
		input [4:0] sel;
		input run;
		input fault;
		begin
			if (sel == `DTIO_FUNC_RUN) begin
				dtio_func = run;
			end else if (sel == `DTIO_FUNC_FAULT) begin
				dtio_func = fault;
			end else begin
				dtio_func = 1'b0;
			end
		end
	endfunction

	reg [15:0] pulse_count;
	reg pulse_level;

	assign fast_pulse_output_mode = ~fast_output_mode_param;

	// square wave whose half period is never below the 100 kHz limit
	always @(posedge aclk) begin
		if (!aresetn || fast_output_mode_param) begin
			pulse_count <= 16'h0000;
			pulse_level <= 1'b0;
		end else if (pulse_count >= pulse_half_period - 16'h0001) begin
			pulse_count <= 16'h0000;
			pulse_level <= ~pulse_level;
		end else begin
			pulse_count <= pulse_count + 16'h0001;
		end
	end

	// function routing and fast terminal mux
	always @(posedge aclk) begin
		if (!aresetn) begin
			open_collector_switch_output <= 1'b0;
			first_relay_contact <= 1'b0;
			fast_multiplexed_output <= 1'b0;
		end else begin
			open_collector_switch_output <= dtio_func(switch_output_function_param,
				drive_running, drive_faulted);
			first_relay_contact <= dtio_func(relay_one_function_param, drive_running,
				drive_faulted);
			if (fast_output_mode_param) begin
				fast_multiplexed_output <= dtio_func(switch_output_function_param,
					drive_running, drive_faulted);
			end else begin
				fast_multiplexed_output <= pulse_level;
			end
		end
	end

	// status word for software
	assign status_word = {23'h000000, fast_pulse_output_mode, fast_multiplexed_output,
		first_relay_contact, open_collector_switch_output, digital_active};

endmodule

// ===== dtio_top_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the terminal block
// ----------------------------------------
module dtio_checker #(
	parameter TICK_CYCLES = 10 // cycles per 0.1 s
) (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, active low
	input wire s_axi_awready, // write address ready
	input wire s_axi_wready, // write data ready
	input wire s_axi_bvalid, // write response valid
	input wire s_axi_arvalid, // read address valid
	input wire s_axi_arready, // read address ready
	input wire s_axi_rvalid, // read data valid
	input wire [47:0] analog_scaled, // curve results
	input wire [47:0] analog_min_setting, // minimum settings
	input wire [2:0] analog_below_min, // below minimum flags
	input wire [47:0] analog_result, // conditioned results
	input wire [8:0] analog_curve_code, // curve codes
	input wire [2:0] analog_four_point, // four-point flags
	input wire digital_in_one, // terminal one pin
	input wire digital_in_four, // terminal four pin
	input wire [4:0] digital_active, // accepted states
	input wire fast_multiplexed_output, // fast terminal
	input wire fast_pulse_output_mode // pulse mode flag
);
	localparam int MIN_RUN = 1249;
	logic [15:0] run;
	logic seen;
	logic prev;
	wire toggle = fast_multiplexed_output ^ prev;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// length of each level run of the pulse wave
	always @(posedge aclk) begin
		prev <= fast_multiplexed_output;
		if (!aresetn || !fast_pulse_output_mode) begin
			run <= 16'h0;
			seen <= 1'b0;
		end else if (toggle) begin
			run <= 16'h0;
			seen <= 1'b1;
		end else if (run != 16'hffff) begin
			run <= run + 16'h1;
		end
	end
	a_curve_range: assert property (
		analog_curve_code[2:0] inside {[3'h1:3'h5]} && analog_curve_code[5:3] inside {[3'h1:3'h5]}
		&& analog_curve_code[8:6] inside {[3'h1:3'h5]}) else $error("curve code out of range");
	a_four_point: assert property (
		analog_four_point == {analog_curve_code[8:6] >= 3'h4, analog_curve_code[5:3] >= 3'h4,
		analog_curve_code[2:0] >= 3'h4}) else $error("four-point flag wrong");
	a_result_pass: assert property (
		$past(aresetn) && $past(analog_below_min) == 3'h0 |-> analog_result == $past(analog_scaled))
		else $error("result not the curve value");
	a_below_choice: assert property (
		$past(aresetn) && $past(analog_below_min[0]) |-> analog_result[15:0] == 16'h0
		|| analog_result[15:0] == $past(analog_min_setting[15:0])) else $error("below value wrong");
	a_pulse_rate: assert property (
		seen && toggle |-> run >= MIN_RUN) else $error("pulse too fast");
	a_in_four_direct: assert property (
		$changed(digital_in_four) |-> ##2 $changed(digital_active[3])) else $error("terminal four late");
	a_in_one_holdoff: assert property (
		$changed(digital_in_one) |=> $stable(digital_active[0]) [*2]) else $error("terminal one early");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	a_write_quiet: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during response");
endmodule

bind dtio_top dtio_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ===== dtio_field_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// field switches on the digital terminals
// ----------------------------------------
module dtio_field_model (
	input wire [4:0] closed, // switch closed to ground
	output wire [4:0] pins // terminal levels
);
	// closed switch grounds the pin, an open one is pulled high
	assign pins = ~closed;
endmodule

// ===== dtio_top_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module dtio_top_test;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, drive_running = 0, drive_faulted = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [47:0] analog_scaled = 0, analog_min_setting = 0;
	logic [2:0] analog_below_min = 0;
	logic [4:0] closed = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [47:0] analog_result;
	wire [8:0] analog_curve_code;
	wire [2:0] analog_four_point;
	wire [4:0] pins, digital_active;
	wire fast_multiplexed_output, fast_pulse_output_mode;
	wire open_collector_switch_output, first_relay_contact;
	wire digital_in_one = pins[0], digital_in_two = pins[1], digital_in_three = pins[2];
	wire digital_in_four = pins[3], digital_in_five = pins[4];
	int n_mismatch = 0, comparisons = 0, cycles = 0;
	dtio_top #(.TICK_CYCLES(10)) DUT (.*);
	dtio_field_model u_field (.closed(closed), .pins(pins));
	// clock and hang guard
	always #2 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ----------------------------------------
	// bus and helper tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
		bit done;
		done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				done = 1;
				s_axi_bready <= 0;
				`CHK("bresp", er, s_axi_bresp)
			end
		end
	endtask
	task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
		bit done;
		done = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				done = 1;
				s_axi_rready <= 0;
				`CHK("rdata", ed, s_axi_rdata)
				`CHK("rresp", er, s_axi_rresp)
			end
		end
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(8'h00, 32'h321, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
		rd(8'h14, 32'h0, 2'h0);
		rd(8'h18, 32'h0, 2'h0);
		rd(8'h1c, 32'h0, 2'h0);
		rd(8'h20, 32'h2, 2'h0);
		rd(8'h24, 32'h4e2, 2'h0);
		rd(8'h28, 32'h100, 2'h0);
		rd(8'h2c, 32'h0, 2'h2);
		wr(8'h2c, 32'hffff, 2'h2);
		wr(8'h28, 32'h1ff, 2'h2);
		wr(8'h24, 32'h10, 2'h0);
		rd(8'h24, 32'h4e2, 2'h0);
		@(posedge aclk);
		s_axi_wstrb <= 4'h1;
		wr(8'h0c, 32'h1234, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(8'h0c, 32'h34, 2'h0);
	endtask
	task automatic t_curve;
		for (int v = 1; v <= 5; v++) begin
			wr(8'h00, {20'h0, v[3:0], v[3:0], v[3:0]}, 2'h0);
			cyc(2);
			`CHK("curve", {3{v[2:0]}}, analog_curve_code)
			`CHK("fourpt", (v > 3) ? 3'h7 : 3'h0, analog_four_point)
		end
		wr(8'h00, 32'h0f6, 2'h0);
		cyc(2);
		`CHK("curve", 9'h049, analog_curve_code)
		wr(8'h00, 32'h123, 2'h0);
		cyc(2);
		`CHK("curve", {3'h1, 3'h2, 3'h3}, analog_curve_code)
	endtask
	task automatic t_below;
		@(posedge aclk);
		analog_scaled <= 48'h3333_2222_1111;
		analog_min_setting <= 48'h0ccc_0bbb_0aaa;
		cyc(2);
		`CHK("scaled", 48'h3333_2222_1111, analog_result)
		wr(8'h04, 32'h010, 2'h0);
		@(posedge aclk);
		analog_below_min <= 3'h7;
		cyc(2);
		`CHK("below", 48'h0ccc_0000_0aaa, analog_result)
		wr(8'h04, 32'h101, 2'h0);
		cyc(2);
		`CHK("below", 48'h0000_0bbb_0000, analog_result)
		@(posedge aclk);
		analog_below_min <= 3'h0;
	endtask
	task automatic t_pins;
		@(posedge aclk);
		closed <= 5'h08;
		cyc(1);
		`CHK("in4", 1'b0, digital_active[3])
		cyc(1);
		`CHK("in4", 1'b1, digital_active[3])
		wr(8'h14, 32'h10000, 2'h0);
		cyc(4);
		`CHK("in5", 1'b1, digital_active[4])
		@(posedge aclk);
		closed <= 5'h18;
		cyc(2);
		`CHK("in5", 1'b0, digital_active[4])
		wr(8'h14, 32'h0, 2'h0);
		@(posedge aclk);
		closed <= 5'h00;
		cyc(4);
	endtask
	task automatic t_delay;
		wr(8'h08, 32'h3, 2'h0);
		wr(8'h0c, 32'h3, 2'h0);
		@(posedge aclk);
		closed <= 5'h07;
		cyc(2);
		`CHK("in3", 3'h0, digital_active[2:0])
		cyc(1);
		`CHK("in3", 3'h4, digital_active[2:0])
		@(posedge aclk);
		closed <= 5'h05;
		cyc(16);
		`CHK("held", 3'h4, digital_active[2:0])
		cyc(16);
		`CHK("done", 3'h5, digital_active[2:0])
	endtask
	task automatic t_outputs;
		logic v;
		int k;
		@(posedge aclk);
		drive_running <= 1;
		drive_faulted <= 1;
		cyc(2);
		`CHK("relay", 1'b1, first_relay_contact)
		`CHK("switch", 1'b0, open_collector_switch_output)
		wr(8'h1c, 32'h1, 2'h0);
		cyc(2);
		`CHK("switch", 1'b1, open_collector_switch_output)
		wr(8'h20, 32'h0, 2'h0);
		cyc(2);
		`CHK("relay", 1'b0, first_relay_contact)
		wr(8'h18, 32'h1, 2'h0);
		cyc(2);
		`CHK("mode", 1'b0, fast_pulse_output_mode)
		`CHK("fast", 1'b1, fast_multiplexed_output)
		@(posedge aclk);
		drive_running <= 0;
		cyc(2);
		`CHK("switch", 1'b0, open_collector_switch_output)
		`CHK("fast", 1'b0, fast_multiplexed_output)
		wr(8'h1c, 32'h2, 2'h0);
		cyc(2);
		`CHK("switch", 1'b1, open_collector_switch_output)
		wr(8'h18, 32'h0, 2'h0);
		cyc(2);
		`CHK("mode", 1'b1, fast_pulse_output_mode)
		for (int i = 0; i < 2; i++) begin
			v = fast_multiplexed_output;
			k = 0;
			while (fast_multiplexed_output === v && k < 3000) begin
				cyc(1);
				k++;
			end
		end
		`CHK("half", 1250, k)
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		cyc(1);
		t_regs();
		t_curve();
		t_below();
		t_pins();
		t_delay();
		t_outputs();
		end_sim();
	end
endmodule
